// File: common/btc_defs.svh
// offsets, field positions, reset values and timing counts of the terminal control block
`ifndef BTC_DEFS_SVH
`define BTC_DEFS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BTC_CLK_NS 100
`define BTC_BIT_NS 1000
`define BTC_BIT_CYC (`BTC_BIT_NS / `BTC_CLK_NS)
`define BTC_HALF_CYC (`BTC_BIT_CYC / 2)
`define BTC_RST_MIN_NS 1000
`define BTC_RST_CYC ((`BTC_RST_MIN_NS + `BTC_CLK_NS - 1) / `BTC_CLK_NS)
`define BTC_FAILSAFE_US 768
`define BTC_FAILSAFE_CYC ((`BTC_FAILSAFE_US * 1000) / `BTC_CLK_NS)
`define BTC_TX_BITS 19
`define BTC_RX_BITS 18
// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define BTC_OFS_CTRL 8'h00
`define BTC_OFS_STATUS 8'h04
`define BTC_OFS_RXWORD 8'h08
`define BTC_OFS_TXWORD 8'h0c
`define BTC_CTRL_TXINH 0
`define BTC_CTRL_RST 1'h0
`define BTC_ADDR_HI 15
`define BTC_ADDR_LO 11
`define BTC_SUB_HI 9
`define BTC_SUB_LO 5
`define BTC_ALL_ONES5 5'h1f
`define BTC_ALL_ZERO5 5'h00
`endif

// File: common/btc_pkg.sv
// types of the terminal control block
package btc_pkg;
  typedef enum logic {TX_IDLE, TX_SHIFT} btc_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} btc_rx_state_t;
  typedef struct packed {
    logic address_match;
    logic broadcast;
    logic mode_code_n;
    logic sync_type;
    logic valid_word_n;
    logic fail_safe;
    logic parity_ok;
  } btc_flags_t;
endpackage

// File: hdl/btc_terminal.sv
// control, flag and shifting logic of the serial bus remote terminal
//
// Notes on behaviour
// - decoder reset low 1 us: decoder idle, sync type low, valid word high
// - tx window high exactly while transmit shifting is in progress
// - self test: transceiver disabled, encoder output looped into decoder
// - fail-safe cleared by terminal enable rising or master reset
// - address match high after valid command with own address and parity
// - mode code low after valid command with subaddress all ones or zeros
// - low-byte latch high passes D0..D7 to first rank, low holds
// - encoder go low starts transmit at next tx shift clock fall
// - broadcast high after valid command to all ones, unless inhibited
// - selects, latches and encoder go act only while channel select low
// - parity check enable low: parity ok high when strap parity odd
// - 16-bit tri-state parallel bus, bit 15 most significant
// - tx shift clock rises advance transmit shifting while tx window high
// - sync type low after data word, high after command; valid word low
// - master reset low 1 us resets decoder, fail-safe and transmit
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "btc_defs.svh"
module btc_terminal
  import btc_pkg::*;
#(
  parameter int FAILSAFE_CYC = `BTC_FAILSAFE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] bus_data_i,
  output logic [15:0] bus_data_o,
  output logic [15:0] bus_data_oe_o,
  input wire logic channel_select_n_i,
  input wire logic data_select_hi_n_i,
  input wire logic data_select_lo_n_i,
  input wire logic latch_hi_i,
  input wire logic latch_lo_i,
  input wire logic load_tx_n_i,
  input wire logic encoder_go_n_i,
  input wire logic sync_select_i,
  input wire logic self_test_i,
  input wire logic decoder_reset_n_i,
  input wire logic master_reset_n_i,
  input wire logic terminal_enable_event_i,
  input wire logic all_terminals_inhibit_n_i,
  input wire logic parity_check_enable_n_i,
  input wire logic [4:0] term_addr_i,
  input wire logic term_addr_parity_i,
  input wire logic rx_serial_i,
  output logic tx_serial_o,
  output logic tx_enable_o,
  output logic tx_shift_clock_o,
  output logic tx_window_o,
  output logic rx_shift_clock_o,
  output logic rx_window_n_o,
  output btc_flags_t flags_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic low_filter(input logic pin_n, input logic [3:0] cnt);
    low_filter = !pin_n && (cnt >= 4'(`BTC_RST_CYC - 1));
  endfunction

  // ----------------------------------------------------------------
  // reset filters
  // ----------------------------------------------------------------
  logic [3:0] master_reset_n_cnt_r;
  logic [3:0] drst_cnt_r;
  logic master_reset_n_hit;
  logic drst_hit;
  assign master_reset_n_hit = low_filter(master_reset_n_i, master_reset_n_cnt_r);
  assign drst_hit = low_filter(decoder_reset_n_i, drst_cnt_r) || master_reset_n_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i || master_reset_n_i) begin
      master_reset_n_cnt_r <= 4'h0;
    end else if (!master_reset_n_hit) begin
      master_reset_n_cnt_r <= master_reset_n_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || decoder_reset_n_i) begin
      drst_cnt_r <= 4'h0;
    end else if (!low_filter(decoder_reset_n_i, drst_cnt_r)) begin
      drst_cnt_r <= drst_cnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // control register and wishbone slave
  // ----------------------------------------------------------------
  logic ctrl_txinh_r;
  logic wb_req;
  logic [15:0] tx1_r;
  logic [15:0] tx2_r;
  logic [15:0] rx1_r;
  logic [15:0] rx2_r;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_txinh_r <= `BTC_CTRL_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `BTC_OFS_CTRL) begin
      ctrl_txinh_r <= wb_dat_i[`BTC_CTRL_TXINH];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `BTC_OFS_CTRL) begin
          wb_dat_o <= {31'h0, ctrl_txinh_r};
        end else if (wb_adr_i == `BTC_OFS_STATUS) begin
          wb_dat_o <= {23'h0, tx_window_o, rx_window_n_o, 7'(flags_o)};
        end else if (wb_adr_i == `BTC_OFS_RXWORD) begin
          wb_dat_o <= {16'h0, rx2_r};
        end else if (wb_adr_i == `BTC_OFS_TXWORD) begin
          wb_dat_o <= {16'h0, tx2_r};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // parallel side
  // ----------------------------------------------------------------
  logic chan_on;
  assign chan_on = !channel_select_n_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx1_r <= 16'h0;
    end else begin
      if (chan_on && latch_hi_i) begin
        tx1_r[15:8] <= bus_data_i[15:8];
      end
      if (chan_on && latch_lo_i) begin
        tx1_r[7:0] <= bus_data_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx2_r <= 16'h0;
    end else if (!load_tx_n_i) begin
      tx2_r <= tx1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_data_o <= 16'h0;
      bus_data_oe_o <= 16'h0;
    end else begin
      bus_data_o <= rx2_r;
      bus_data_oe_o <= {{8{chan_on && !data_select_hi_n_i}},
                        {8{chan_on && !data_select_lo_n_i}}};
    end
  end

  // ----------------------------------------------------------------
  // encoder: shift clock, transmit shifting and fail-safe
  // ----------------------------------------------------------------
  btc_tx_state_t tx_state_r;
  logic [3:0] tx_div_r;
  logic [4:0] tx_bits_r;
  logic [18:0] tx_shift_r;
  logic [12:0] fs_cnt_r;
  logic tx_rise;
  logic tx_fall;
  logic tx_start;
  logic fs_trip;
  logic tev_d_r;
  assign tx_rise = tx_div_r == 4'(`BTC_BIT_CYC - 1);
  assign tx_fall = tx_div_r == 4'(`BTC_HALF_CYC - 1);
  assign tx_start = tx_state_r == TX_IDLE && tx_fall && chan_on && !encoder_go_n_i
                    && !flags_o.fail_safe;
  assign fs_trip = tx_state_r == TX_SHIFT && fs_cnt_r == 13'(FAILSAFE_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_rise) begin
      tx_div_r <= 4'h0;
    end else begin
      tx_div_r <= tx_div_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_shift_clock_o <= 1'b0;
    end else begin
      tx_shift_clock_o <= tx_rise || (tx_div_r < 4'(`BTC_HALF_CYC - 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || master_reset_n_hit || fs_trip) begin
      tx_state_r <= TX_IDLE;
      tx_bits_r <= 5'h0;
      tx_shift_r <= 19'h0;
    end else if (tx_start) begin
      tx_state_r <= TX_SHIFT;
      tx_bits_r <= 5'(`BTC_TX_BITS);
      tx_shift_r <= {1'b1, sync_select_i, tx2_r, ~^tx2_r};
    end else if (tx_state_r == TX_SHIFT && tx_rise) begin
      tx_shift_r <= {tx_shift_r[17:0], 1'b0};
      tx_bits_r <= tx_bits_r - 5'h1;
      if (tx_bits_r == 5'h1) begin
        tx_state_r <= TX_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_state_r == TX_IDLE && encoder_go_n_i) begin
      fs_cnt_r <= 13'h0;
    end else if (tx_state_r == TX_SHIFT && !fs_trip) begin
      fs_cnt_r <= fs_cnt_r + 13'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tev_d_r <= 1'b0;
    end else begin
      tev_d_r <= terminal_enable_event_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_window_o <= 1'b0;
      tx_serial_o <= 1'b0;
      tx_enable_o <= 1'b0;
    end else begin
      tx_window_o <= tx_state_r == TX_SHIFT && !fs_trip && !master_reset_n_hit;
      tx_serial_o <= tx_state_r == TX_SHIFT && tx_shift_r[18];
      tx_enable_o <= !self_test_i && !ctrl_txinh_r;
    end
  end

  // ----------------------------------------------------------------
  // decoder: receive shifting and command decode
  // ----------------------------------------------------------------
  btc_rx_state_t rx_state_r;
  logic [3:0] rx_div_r;
  logic [4:0] rx_bits_r;
  logic rx_sync_r;
  logic rx_line;
  logic rx_sample;
  logic rx_done;
  logic [16:0] rx_word;
  logic cmd_ok;
  logic rx_prev_r;
  assign rx_line = self_test_i ? tx_serial_o : rx_serial_i;
  assign rx_sample = rx_div_r == 4'(`BTC_BIT_CYC - 1);
  assign rx_done = rx_state_r == RX_SHIFT && rx_sample && rx_bits_r == 5'h1;
  assign rx_word = {rx1_r[15:0], rx_line};
  assign cmd_ok = rx_done && rx_sync_r && ^{rx1_r, rx_line};

  // a start needs a fresh rise, so a trailing parity one is no start bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_line;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || drst_hit) begin
      rx_state_r <= RX_IDLE;
      rx_div_r <= 4'h0;
      rx_bits_r <= 5'h0;
      rx_sync_r <= 1'b0;
      rx1_r <= 16'h0;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_div_r <= 4'h0;
          if (rx_line && !rx_prev_r) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          rx_div_r <= rx_div_r + 4'h1;
          if (rx_div_r == 4'(`BTC_HALF_CYC - 1)) begin
            // start bit is half a bit long, so sync centre is half a bit on
            rx_div_r <= 4'(`BTC_HALF_CYC);
            rx_state_r <= RX_SHIFT;
            rx_bits_r <= 5'(`BTC_RX_BITS);
          end
        end
        default: begin
          rx_div_r <= rx_sample ? 4'h0 : rx_div_r + 4'h1;
          if (rx_sample) begin
            rx_bits_r <= rx_bits_r - 5'h1;
            if (rx_bits_r == 5'(`BTC_RX_BITS)) begin
              rx_sync_r <= rx_line;
            end else if (rx_bits_r != 5'h1) begin
              rx1_r <= {rx1_r[14:0], rx_line};
            end else begin
              rx_state_r <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || drst_hit) begin
      rx_window_n_o <= 1'b1;
      rx_shift_clock_o <= 1'b0;
    end else begin
      rx_window_n_o <= rx_state_r != RX_SHIFT || rx_done;
      rx_shift_clock_o <= rx_state_r == RX_SHIFT && rx_sample && rx_bits_r > 5'h1
                          && rx_bits_r != 5'(`BTC_RX_BITS);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx2_r <= 16'h0;
    end else if (rx_done) begin
      rx2_r <= rx1_r;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || master_reset_n_hit) begin
      flags_o.fail_safe <= 1'b0;
    end else if (fs_trip) begin
      flags_o.fail_safe <= 1'b1;
    end else if (terminal_enable_event_i && !tev_d_r) begin
      flags_o.fail_safe <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_o.parity_ok <= 1'b0;
    end else begin
      flags_o.parity_ok <= !parity_check_enable_n_i && ^{term_addr_i, term_addr_parity_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || drst_hit) begin
      flags_o.sync_type <= 1'b0;
      flags_o.valid_word_n <= 1'b1;
    end else if (rx_state_r == RX_START) begin
      flags_o.valid_word_n <= 1'b1;
    end else if (rx_done) begin
      flags_o.sync_type <= rx_sync_r;
      flags_o.valid_word_n <= !(^{rx1_r, rx_line});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || drst_hit) begin
      flags_o.address_match <= 1'b0;
      flags_o.broadcast <= 1'b0;
      flags_o.mode_code_n <= 1'b1;
    end else if (cmd_ok) begin
      flags_o.address_match <= rx_word[`BTC_ADDR_HI+1:`BTC_ADDR_LO+1] == term_addr_i
                               && ^{term_addr_i, term_addr_parity_i};
      flags_o.broadcast <= rx_word[`BTC_ADDR_HI+1:`BTC_ADDR_LO+1] == `BTC_ALL_ONES5
                           && all_terminals_inhibit_n_i;
      flags_o.mode_code_n <= !(rx_word[`BTC_SUB_HI+1:`BTC_SUB_LO+1] == `BTC_ALL_ONES5
                               || rx_word[`BTC_SUB_HI+1:`BTC_SUB_LO+1] == `BTC_ALL_ZERO5);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_go_at_fall;
    tx_state_r == TX_IDLE && tx_fall && chan_on && !encoder_go_n_i && !flags_o.fail_safe
    && !master_reset_n_hit && !fs_trip;
  endsequence
  sequence s_window_up;
    tx_state_r == TX_SHIFT ##1 tx_window_o;
  endsequence

  a_tx_start_edge: assert property (s_go_at_fall |=> s_window_up)
    else $error("transmit did not start at shift clock fall");
  a_tx_window_busy: assert property (tx_window_o |-> $past(tx_state_r) == TX_SHIFT)
    else $error("tx window high while not shifting");
  a_fail_safe_set: assert property (fs_trip && !master_reset_n_hit |=> flags_o.fail_safe && !tx_window_o)
    else $error("fail-safe not raised on overlong message");
  a_fail_safe_clear: assert property ($rose(terminal_enable_event_i) && !fs_trip
                                      |=> !flags_o.fail_safe)
    else $error("fail-safe not cleared");
  a_dec_reset: assert property (drst_hit |=> !flags_o.sync_type && flags_o.valid_word_n
                                && rx_state_r == RX_IDLE)
    else $error("decoder reset incomplete");
  a_addr_match: assert property (cmd_ok && rx_word[16:12] == term_addr_i
                                 && ^{term_addr_i, term_addr_parity_i} && !drst_hit
                                 |=> flags_o.address_match)
    else $error("address match flag missing");
  a_mode_code: assert property (cmd_ok && rx_word[10:6] == 5'h00 && !drst_hit
                                |=> !flags_o.mode_code_n)
    else $error("mode code flag missing");
  a_latch_hold: assert property (!(chan_on && latch_lo_i) |=> $stable(tx1_r[7:0]))
    else $error("low byte latch changed while locked");
  a_bus_drive: assert property (bus_data_oe_o != 16'h0 |-> $past(chan_on))
    else $error("bus driven without channel select");
  a_wrap_tx_off: assert property (self_test_i |=> !tx_enable_o)
    else $error("transceiver enabled during self test");
  a_rx_copy: assert property ($rose(rx_window_n_o) && !$past(drst_hit) |-> rx2_r == $past(rx1_r))
    else $error("second rank not loaded at window rise");

endmodule
`default_nettype wire

// File: verification/btc_host_model.sv
// subsystem controller model on the parallel tri-state data highway
`timescale 1ns/1ps
`default_nettype none
module btc_host_model (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] dut_data_i,
  input wire logic [15:0] dut_oe_i,
  output logic [15:0] bus_o
);
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  logic [15:0] last_r;
  // a released bit shows the inverse of its last level
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (dut_oe_i[i]) begin
        bus_o[i] = dut_data_i[i];
      end else if (drive_i) begin
        bus_o[i] = data_i[i];
      end else begin
        bus_o[i] = ~last_r[i];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    last_r <= bus_o;
  end
endmodule
`default_nettype wire

// File: verification/btc_terminal_tb.sv
// self-checking bench of the terminal control block
`timescale 1ns/1ps
`default_nettype none
module btc_terminal_tb;
  import btc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_i = 0;
  logic rst_i = 1;
  logic wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, wb_dat_o;
  logic wb_ack_o;
  logic [15:0] bus_i, bus_o, bus_oe, host_data = 16'h0;
  logic host_drive = 0, chan_n = 0, latch_hi = 0, latch_lo = 0, load_n = 1, go_n = 1;
  logic [1:0] dsel = 2'b11;
  logic sync_sel = 0, decoder_reset_n_n = 1, master_reset_n_n = 1, term_en = 0, inh_n = 1, st = 1, par_en_n = 0;
  logic tx_ser, tx_en, tx_sck, tx_window, rx_sck, rx_window_n;
  btc_flags_t flags;
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'hcad2;
  int num_errors = 0, compares = 0, rx_cnt = 0;
  btc_terminal #(.FAILSAFE_CYC(200)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus_data_i(bus_i), .bus_data_o(bus_o), .bus_data_oe_o(bus_oe),
    .channel_select_n_i(chan_n), .data_select_hi_n_i(dsel[1]), .data_select_lo_n_i(dsel[0]),
    .latch_hi_i(latch_hi), .latch_lo_i(latch_lo), .load_tx_n_i(load_n),
    .encoder_go_n_i(go_n), .sync_select_i(sync_sel), .self_test_i(st),
    .decoder_reset_n_i(decoder_reset_n_n), .master_reset_n_i(master_reset_n_n),
    .terminal_enable_event_i(term_en), .all_terminals_inhibit_n_i(inh_n),
    .parity_check_enable_n_i(par_en_n), .term_addr_i(5'h05), .term_addr_parity_i(1'b1),
    .rx_serial_i(1'b0), .tx_serial_o(tx_ser), .tx_enable_o(tx_en),
    .tx_shift_clock_o(tx_sck), .tx_window_o(tx_window), .rx_shift_clock_o(rx_sck),
    .rx_window_n_o(rx_window_n), .flags_o(flags)
  );
  btc_host_model u_host (
    .clk_i(clk_i), .drive_i(host_drive), .data_i(host_data), .dut_data_i(bus_o),
    .dut_oe_i(bus_oe), .bus_o(bus_i)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkv(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_xfer(a, 1'b0, 32'h0);
  endtask
  // read data is compared against the oldest note when ack appears
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
      chkv("wb_dat_o", exp_q.pop_front(), wb_dat_o);
    end
    if (rx_sck === 1'b1 && rx_window_n === 1'b0) rx_cnt++;
  end
  // latch a word from the highway, change the bus while latched, then loop it back
  task automatic send_word(input logic [15:0] w, input logic s);
    int n;
    {host_data, host_drive, sync_sel} <= {w, 1'b1, s};
    @(posedge clk_i);
    {latch_hi, latch_lo} <= 2'b11;
    @(posedge clk_i);
    {latch_hi, latch_lo, load_n, host_data} <= {3'b000, ~w};
    @(posedge clk_i);
    {load_n, host_drive, go_n} <= 3'b100;
    rx_cnt = 0;
    for (n = 0; n < 40 && tx_window !== 1'b1; n++) @(posedge clk_i);
    go_n <= 1'b1;
    chk1("tx_window_o", 1'b1, tx_window);
    chk1("tx_enable_o", 1'b0, tx_en);
    for (n = 0; n < 400 && rx_window_n !== 1'b0; n++) @(posedge clk_i);
    for (n = 0; n < 400 && rx_window_n !== 1'b1; n++) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
    chkv("rx_shift_pulses", 32'h10, rx_cnt);
    chk1("tx_window_o", 1'b0, tx_window);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
  initial begin
    int n;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    {chan_n, dsel, go_n} <= 4'b1000;
    repeat (30) @(posedge clk_i);
    chk1("parity_ok", 1'b1, flags.parity_ok);
    chk1("tx_window_o", 1'b0, tx_window);
    chkv("bus_data_oe_o", 32'h0, {16'h0, bus_oe});
    {st, par_en_n} <= 2'b01;
    repeat (2) @(posedge clk_i);
    chk1("parity_ok", 1'b0, flags.parity_ok);
    chk1("tx_enable_o", 1'b1, tx_en);
    wb_rd(8'h04, 32'h94);
    wb_xfer(8'h00, 1'b1, 32'h1);
    wb_rd(8'h00, 32'h1);
    chk1("tx_enable_o", 1'b0, tx_en);
    wb_xfer(8'h00, 1'b1, 32'h0);
    {st, par_en_n} <= 2'b10;
    {chan_n, dsel, go_n} <= 4'b0111;
    send_word(16'h2bea, 1'b1);
    chk1("address_match", 1'b1, flags.address_match);
    chk1("mode_code_n", 1'b0, flags.mode_code_n);
    chk1("sync_type", 1'b1, flags.sync_type);
    chk1("valid_word_n", 1'b0, flags.valid_word_n);
    wb_rd(8'h08, 32'h2bea);
    wb_rd(8'h10, 32'h0);
    dsel <= 2'b00;
    repeat (3) @(posedge clk_i);
    chkv("bus_data_oe_o", 32'hffff, {16'h0, bus_oe});
    chkv("bus_data", 32'h2bea, {16'h0, bus_i});
    dsel <= 2'b11;
    for (int i = 0; i < 2; i++) begin
      inh_n <= i[0];
      send_word(i[0] ? 16'hfc00 : 16'hfc60, 1'b1);
      chk1("broadcast", i[0], flags.broadcast);
      chk1("address_match", 1'b0, flags.address_match);
      chk1("mode_code_n", !i[0], flags.mode_code_n);
    end
    decoder_reset_n_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    decoder_reset_n_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk1("sync_type", 1'b0, flags.sync_type);
    chk1("valid_word_n", 1'b1, flags.valid_word_n);
    rnd = lfsr(rnd);
    send_word(rnd[15:0], 1'b0);
    chk1("sync_type", 1'b0, flags.sync_type);
    wb_rd(8'h08, {16'h0, rnd[15:0]});
    wb_rd(8'h0c, {16'h0, rnd[15:0]});
    go_n <= 1'b0;
    for (n = 0; n < 600 && flags.fail_safe !== 1'b1; n++) @(posedge clk_i);
    chk1("fail_safe", 1'b1, flags.fail_safe);
    repeat (20) @(posedge clk_i);
    chk1("tx_window_o", 1'b0, tx_window);
    go_n <= 1'b1;
    repeat (5) @(posedge clk_i);
    term_en <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1("fail_safe", 1'b0, flags.fail_safe);
    {term_en, go_n} <= 2'b00;
    for (n = 0; n < 40 && tx_window !== 1'b1; n++) @(posedge clk_i);
    go_n <= 1'b1;
    repeat (20) @(posedge clk_i);
    master_reset_n_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    master_reset_n_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk1("tx_window_o", 1'b0, tx_window);
    chk1("valid_word_n", 1'b1, flags.valid_word_n);
    chk1("fail_safe", 1'b0, flags.fail_safe);
    repeat (5) @(posedge clk_i);
    summarize();
  end
endmodule
`default_nettype wire
